/* File: dv/rrbo_core_bench.sv */
`timescale 1ns/1ns
`default_nettype none
// =========================================
// Self-checking bench for the return/rotate/bit group
module rrbo_core_bench;
	// Row: opcode, operand, carry in, mem/W strobes, result, carry out, status strobe
	typedef struct packed
	{
		logic [15:0] op;
		logic [7:0]  rd;
		logic        c;
		logic        mwe;
		logic        wwe;
		logic [7:0]  dat;
		logic        cout;
		logic        swe;
	} rrbo_row_t;
	logic                   clk, rst_n, valid, irq, call, ready, w_we, s_we, sp_we;
	logic [15:0]            opcode, target, pc, p;
	logic [7:0]             rdata, w_in, st_in, sp_in, tmr_in, w_out, st_out, sp_out;
	logic [8:0]             maddr;
	rrbo_pkg::rrbo_mem_wr_t mwr;
	rrbo_pkg::rrbo_side_t   side;
	int                     err_count, total_checks;
	rrbo_row_t              rows [10] = '{
		'{16'h3699, 8'h14, 1, 1, 0, 8'h29, 0, 1}, '{16'h3499, 8'h14, 1, 0, 1, 8'h29, 0, 1},
		'{16'h3299, 8'h12, 1, 1, 0, 8'h89, 0, 1}, '{16'h3099, 8'h12, 1, 0, 1, 8'h89, 0, 1},
		'{16'h37FF, 8'h80, 0, 1, 0, 8'h00, 1, 1}, '{16'h3001, 8'h01, 0, 0, 1, 8'h00, 1, 1},
		'{16'h5099, 8'h00, 0, 1, 0, 8'h01, 0, 0}, '{16'h5E99, 8'h10, 0, 1, 0, 8'h90, 0, 0},
		'{16'h57FF, 8'hF7, 1, 1, 0, 8'hFF, 0, 0}, '{16'h7499, 8'h00, 0, 0, 0, 8'h00, 0, 0}};
	rrbo_core dut_u (.SYS_CLK_IN(clk), .RSTN_IN(rst_n), .OP_VALID_IN(valid), .OPCODE_IN(opcode),
		.OP_READY_OUT(ready), .MEM_RDATA_IN(rdata), .W_IN(w_in), .STATUS_IN(st_in),
		.SPEED_IN(sp_in), .TMR_IN(tmr_in), .IRQ_ENTRY_IN(irq), .CALL_IN(call),
		.CALL_TARGET_IN(target), .MEM_ADDR_OUT(maddr), .MEM_WR_OUT(mwr), .W_WE_OUT(w_we),
		.W_OUT(w_out), .STATUS_WE_OUT(s_we), .STATUS_OUT(st_out), .SPEED_WE_OUT(sp_we),
		.SPEED_OUT(sp_out), .SIDE_OUT(side), .PC_OUT(pc));
	// 100 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// One comparison, reported at once
	task chk(input logic ok, input string m);
		total_checks++;
		if (ok !== 1'b1)
		begin
			err_count++;
			$display("ERROR %0t: %s", $time, m);
		end
	endtask
	// Present one word until the taking edge, then sample once results landed
	task run(input logic [15:0] op, input logic [7:0] rd);
		@(posedge clk);
		valid <= 1'b1;
		opcode <= op;
		rdata <= rd;
		@(posedge clk);
		valid <= 1'b0;
		#1;
	endtask
	// Interrupt entry pulse
	task pulse_irq;
		@(posedge clk);
		irq <= 1'b1;
		@(posedge clk);
		irq <= 1'b0;
		#1;
	endtask
	// Counts and verdict
	task summarize;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Watchdog, far beyond the fewer than one hundred cycles the tests need
	initial
	begin
		#100000;
		err_count++;
		summarize();
	end
	// Main sequence
	initial
	begin
		{rst_n, valid, irq, call, opcode, target, rdata, w_in, st_in, sp_in, tmr_in} = '0;
		repeat (12) @(posedge clk);
		chk(pc === 16'h0000 && ready === 1'b1 && mwr.we === 1'b0, "reset values");
		rst_n <= 1'b1;
		foreach (rows[i])
		begin
			p = pc;
			st_in <= {7'h53, rows[i].c};
			run(rows[i].op, rows[i].rd);
			chk(mwr.we === rows[i].mwe && w_we === rows[i].wwe, "strobes");
			chk(maddr === rows[i].op[8:0], "operand address");
			chk(s_we === rows[i].swe && pc === p + 16'h0001, "status or pc");
			if (rows[i].mwe)
				chk(mwr.data === rows[i].dat && mwr.addr === rows[i].op[8:0], "memory");
			if (rows[i].wwe)
				chk(w_out === rows[i].dat, "W result");
			if (rows[i].swe)
				chk(st_out === {7'h53, rows[i].cout}, "carry");
		end
		$display("row test done");
		p = pc;
		@(posedge clk);
		st_in <= 8'hC3;
		sp_in <= 8'h5A;
		pulse_irq();
		chk(pc === 16'h0000, "reset vector");
		@(posedge clk);
		{st_in, sp_in, w_in, tmr_in} <= {16'h0000, 8'h10, 8'hF5};
		run(16'h000F, 8'h00);
		chk(s_we === 1'b1 && st_out === 8'hC3 && ready === 1'b0, "status restore");
		chk(sp_we === 1'b1 && sp_out === 8'h5A, "speed restore");
		chk(side.vec_we === 1'b1 && {side.vec_hi, side.vec_lo} === 16'h0001, "vector");
		chk(side.tmr_we === 1'b1 && side.tmr === 8'h05, "timer");
		@(posedge clk);
		#1;
		chk(ready === 1'b0, "second wait");
		@(posedge clk);
		#1;
		chk(ready === 1'b1 && pc === p, "return pc");
		pulse_irq();
		chk(pc === 16'h0001, "new vector");
		run(16'h0008, 8'h00);
		chk(s_we === 1'b1 && {sp_we, side.vec_we, side.tmr_we} === 3'b000, "no options");
		repeat (2) @(posedge clk);
		#1;
		$display("interrupt return test done");
		p = pc;
		@(posedge clk);
		call <= 1'b1;
		target <= 16'h1234;
		@(posedge clk);
		call <= 1'b0;
		#1;
		chk(pc === 16'h1234, "call target");
		run(16'h78A5, 8'h00);
		chk(w_we === 1'b1 && w_out === 8'hA5 && s_we === 1'b0, "literal return");
		run(16'h3699, 8'h14);
		chk(mwr.we === 1'b0 && ready === 1'b1 && pc === p + 16'h0001, "refused, popped");
		$display("subroutine return test done");
		p = pc;
		run(16'h7499, 8'h04);
		run(16'h0012, 8'h00);
		run(16'h0013, 8'h00);
		run(16'h3699, 8'h14);
		chk(mwr.we === 1'b0 && pc === p + 16'h0004, "skip with page-loads");
		run(16'h3499, 8'h14);
		chk(w_we === 1'b1 && w_out === 8'h28, "after skip");
		$display("skip test done");
		summarize();
	end
endmodule
`default_nettype wire

/* File: dv/rrbo_properties.sv */
`timescale 1ns/1ns
`default_nettype none
// =========================================
// Port checker for the return/rotate/bit group
module rrbo_properties (
	// Clock and reset
	input wire logic                   SYS_CLK_IN,
	input wire logic                   RSTN_IN,
	// Fetch and operands
	input wire logic                   OP_VALID_IN,
	input wire logic [15:0]            OPCODE_IN,
	input wire logic                   OP_READY_OUT,
	input wire logic [7:0]             MEM_RDATA_IN,
	input wire logic [7:0]             W_IN,
	input wire logic [7:0]             STATUS_IN,
	input wire logic [7:0]             TMR_IN,
	input wire logic                   IRQ_ENTRY_IN,
	// Results
	input wire rrbo_pkg::rrbo_mem_wr_t MEM_WR_OUT,
	input wire logic                   W_WE_OUT,
	input wire logic [7:0]             W_OUT,
	input wire logic                   STATUS_WE_OUT,
	input wire logic [7:0]             STATUS_OUT,
	input wire logic                   SPEED_WE_OUT,
	input wire rrbo_pkg::rrbo_side_t   SIDE_OUT,
	input wire logic [15:0]            PC_OUT
);
	logic skp;  // Words being discarded after a taken skip
	logic exe;  // Opcode really executed at this edge
	logic take; // Skip condition true
	logic pg;   // Page-load word present
	logic acc;  // Word consumed, executed or not
	assign acc = OP_VALID_IN && OP_READY_OUT && !IRQ_ENTRY_IN;
	assign exe = acc && !skp;
	assign pg = (OPCODE_IN & rrbo_pkg::PAGE_MASK) == rrbo_pkg::PAGE_CODE;
	assign take = exe && ((OPCODE_IN & rrbo_pkg::BIT_MASK) == rrbo_pkg::SKIP_CODE)
		&& ((OPCODE_IN & rrbo_pkg::RETW_MASK) != rrbo_pkg::RETW_CODE)
		&& MEM_RDATA_IN[OPCODE_IN[11:9]];
	// Executed opcode matches a pattern
	function automatic logic is_op(input logic [15:0] m, input logic [15:0] c);
		return exe && ((OPCODE_IN & m) == c);
	endfunction
	// Discard tracking; page-loads keep it going so the jump after them is dropped too
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
			skp <= 1'b0;
		else if (acc)
			skp <= take || (skp && pg);
	end
	default clocking cb @(posedge SYS_CLK_IN); endclocking
	default disable iff (!RSTN_IN);
	// =========================================
	// Rotates through carry
	rot_left_mem_a: assert property (is_op(rrbo_pkg::ROT_MASK, rrbo_pkg::RLM_CODE) |=>
		MEM_WR_OUT.we && MEM_WR_OUT.data == {$past(MEM_RDATA_IN[6:0]), $past(STATUS_IN[0])}
		&& STATUS_OUT[0] == $past(MEM_RDATA_IN[7])) else $error("rotate left to memory wrong");
	rot_left_w_a: assert property (is_op(rrbo_pkg::ROT_MASK, rrbo_pkg::RLW_CODE) |=>
		W_WE_OUT && !MEM_WR_OUT.we && W_OUT == {$past(MEM_RDATA_IN[6:0]), $past(STATUS_IN[0])}
		&& STATUS_OUT[0] == $past(MEM_RDATA_IN[7])) else $error("rotate left to W wrong");
	rot_right_mem_a: assert property (is_op(rrbo_pkg::ROT_MASK, rrbo_pkg::RRM_CODE) |=>
		MEM_WR_OUT.we && MEM_WR_OUT.data == {$past(STATUS_IN[0]), $past(MEM_RDATA_IN[7:1])}
		&& STATUS_OUT[0] == $past(MEM_RDATA_IN[0])) else $error("rotate right to memory wrong");
	rot_right_w_a: assert property (is_op(rrbo_pkg::ROT_MASK, rrbo_pkg::RRW_CODE) |=>
		W_WE_OUT && !MEM_WR_OUT.we && W_OUT == {$past(STATUS_IN[0]), $past(MEM_RDATA_IN[7:1])}
		&& STATUS_OUT[0] == $past(MEM_RDATA_IN[0])) else $error("rotate right to W wrong");
	rot_flags_a: assert property (is_op(16'hF800, 16'h3000) |=>
		STATUS_WE_OUT && STATUS_OUT[7:1] == $past(STATUS_IN[7:1])) else $error("rotate flags");
	// Bit set and skip
	bit_set_a: assert property (is_op(rrbo_pkg::BIT_MASK, rrbo_pkg::SETB_CODE) |=>
		MEM_WR_OUT.we && !STATUS_WE_OUT && MEM_WR_OUT.addr == $past(OPCODE_IN[8:0])
		&& MEM_WR_OUT.data == ($past(MEM_RDATA_IN) | (8'h01 << $past(OPCODE_IN[11:9]))))
		else $error("bit set wrong");
	skip_drop_a: assert property (skp && acc |=> !MEM_WR_OUT.we && !W_WE_OUT)
		else $error("skipped word executed");
	// Returns
	ret_len_a: assert property (is_op(rrbo_pkg::RETI_MASK, rrbo_pkg::RETI_CODE)
		|| is_op(rrbo_pkg::RETW_MASK, rrbo_pkg::RETW_CODE) |=> !OP_READY_OUT [*2] ##1 OP_READY_OUT)
		else $error("return length wrong");
	retw_lit_a: assert property (is_op(rrbo_pkg::RETW_MASK, rrbo_pkg::RETW_CODE) |=>
		W_WE_OUT && W_OUT == $past(OPCODE_IN[7:0]) && !STATUS_WE_OUT) else $error("retw wrong");
	reti_opts_a: assert property (is_op(rrbo_pkg::RETI_MASK, rrbo_pkg::RETI_CODE) |=>
		STATUS_WE_OUT && SPEED_WE_OUT == $past(OPCODE_IN[2]) && SIDE_OUT.vec_we == $past(OPCODE_IN[1])
		&& SIDE_OUT.tmr_we == $past(OPCODE_IN[0])) else $error("reti options wrong");
	reti_vec_a: assert property (is_op(16'hFFFA, 16'h000A) |=>
		{SIDE_OUT.vec_hi, SIDE_OUT.vec_lo} == $past(PC_OUT) + 16'h0001) else $error("vector wrong");
	reti_tmr_a: assert property (is_op(16'hFFF9, 16'h0009) |=>
		SIDE_OUT.tmr == $past(TMR_IN) + $past(W_IN)) else $error("timer sum wrong");
endmodule
bind rrbo_core rrbo_properties chk_u (.SYS_CLK_IN(SYS_CLK_IN), .RSTN_IN(RSTN_IN),
	.OP_VALID_IN(OP_VALID_IN), .OPCODE_IN(OPCODE_IN), .OP_READY_OUT(OP_READY_OUT),
	.MEM_RDATA_IN(MEM_RDATA_IN), .W_IN(W_IN), .STATUS_IN(STATUS_IN), .TMR_IN(TMR_IN),
	.IRQ_ENTRY_IN(IRQ_ENTRY_IN), .MEM_WR_OUT(MEM_WR_OUT), .W_WE_OUT(W_WE_OUT), .W_OUT(W_OUT),
	.STATUS_WE_OUT(STATUS_WE_OUT), .STATUS_OUT(STATUS_OUT), .SPEED_WE_OUT(SPEED_WE_OUT),
	.SIDE_OUT(SIDE_OUT), .PC_OUT(PC_OUT));
`default_nettype wire

/* File: rtl/rrbo_core.sv */
// Notes on behaviour
// - Interrupt return reloads saved PC, three cycles.
// - Interrupt return restores whole status from shadow.
// - Option bit 2 reinstates pre-interrupt speed.
// - Option bit 1 stores PC+1 into vector.
// - Option bit 0 adds W to timer.
// - Interrupt entry shadows registers, jumps to vector.
// - Literal return loads W, pops PC, three cycles.
// - Subroutine returns leave page-select bits alone.
// - Call stack separate from data-memory stack.
// - Rotate left into memory through carry.
// - Rotate left into W, memory unchanged.
// - Rotate right into memory through carry.
// - Rotate right into W, memory unchanged.
// - Rotates change only carry among status bits.
// - Skip-if-set: one cycle, two when skipping.
// - Bit-set forces one bit, no flags.
// - Three-bit bit number, nine-bit address.
// - Page-loads after taken skip skipped too.
`timescale 1ns/1ns
`default_nettype none

module rrbo_core #(
	parameter int STACK_DEPTH = 16 // Hardware call stack depth
)(
	// Clock and reset
	input  wire logic                  SYS_CLK_IN,
	input  wire logic                  RSTN_IN,
	// Instruction fetch
	input  wire logic                  OP_VALID_IN,    // Opcode present this cycle
	input  wire logic [15:0]           OPCODE_IN,
	output logic                       OP_READY_OUT,   // Core accepts opcode
	// Operands
	input  wire logic [7:0]            MEM_RDATA_IN,   // Addressed data byte
	input  wire logic [7:0]            W_IN,           // Working register
	input  wire logic [7:0]            STATUS_IN,      // Live status register
	input  wire logic [7:0]            SPEED_IN,       // Live speed setting
	input  wire logic [7:0]            TMR_IN,         // Live timer 0 count
	// Interrupt entry and call
	input  wire logic                  IRQ_ENTRY_IN,   // Interrupt taken (pulse)
	input  wire logic                  CALL_IN,        // Call pushes a return unless an opcode fires in the same cycle
	input  wire logic [15:0]           CALL_TARGET_IN,
	// Results
	output logic [8:0]                 MEM_ADDR_OUT,   // Operand address
	output rrbo_pkg::rrbo_mem_wr_t     MEM_WR_OUT,
	output logic                       W_WE_OUT,
	output logic [7:0]                 W_OUT,
	output logic                       STATUS_WE_OUT,
	output logic [7:0]                 STATUS_OUT,
	output logic                       SPEED_WE_OUT,
	output logic [7:0]                 SPEED_OUT,
	output rrbo_pkg::rrbo_side_t       SIDE_OUT,
	output logic [15:0]                PC_OUT
);

	// ==========================================================
	// Elaboration check
	initial
	begin
		if (STACK_DEPTH < 2 || STACK_DEPTH > 256)
			$error("STACK_DEPTH out of range");
	end

	localparam int SPW = $clog2(STACK_DEPTH);

	// ==========================================================
	// Decode helpers
	function automatic logic match(input logic [15:0] op, input logic [15:0] m,
		input logic [15:0] c);
		match = (op & m) == c;
	endfunction

	// ==========================================================
	// State
	rrbo_pkg::rrbo_state_t state;            // Sequencer state
	logic [1:0]            cyc;              // Remaining extra cycles
	logic [15:0]           pc;               // Program counter
	logic [15:0]           vec;              // Interrupt vector pair
	logic [15:0]           shadow_pc;        // PC saved at entry
	logic [7:0]            shadow_status;    // Status saved at entry
	logic [7:0]            shadow_speed;     // Speed saved at entry
	logic [15:0]           stack [STACK_DEPTH]; // Call return addresses
	logic [SPW-1:0]        sp;               // Call stack pointer
	logic [15:0]           ret_target;       // Latched return destination

	// Decoded opcode
	logic is_reti;
	logic is_retw;
	logic is_rlm;
	logic is_rlw;
	logic is_rrm;
	logic is_rrw;
	logic is_skip;
	logic is_setb;
	logic is_page;
	logic [2:0] bit_sel;
	logic tested;
	logic carry;
	logic [7:0] rot_l;
	logic [7:0] rot_r;

	always_comb
	begin
		is_reti = match(OPCODE_IN, rrbo_pkg::RETI_MASK, rrbo_pkg::RETI_CODE);
		is_retw = match(OPCODE_IN, rrbo_pkg::RETW_MASK, rrbo_pkg::RETW_CODE);
		is_rlm  = match(OPCODE_IN, rrbo_pkg::ROT_MASK, rrbo_pkg::RLM_CODE);
		is_rlw  = match(OPCODE_IN, rrbo_pkg::ROT_MASK, rrbo_pkg::RLW_CODE);
		is_rrm  = match(OPCODE_IN, rrbo_pkg::ROT_MASK, rrbo_pkg::RRM_CODE);
		is_rrw  = match(OPCODE_IN, rrbo_pkg::ROT_MASK, rrbo_pkg::RRW_CODE);
		// Literal return shares the upper nibble, so exclude it
		is_skip = match(OPCODE_IN, rrbo_pkg::BIT_MASK, rrbo_pkg::SKIP_CODE) && !is_retw;
		is_setb = match(OPCODE_IN, rrbo_pkg::BIT_MASK, rrbo_pkg::SETB_CODE);
		is_page = match(OPCODE_IN, rrbo_pkg::PAGE_MASK, rrbo_pkg::PAGE_CODE);
		bit_sel = OPCODE_IN[rrbo_pkg::BITSEL_LO +: 3];
		tested  = MEM_RDATA_IN[bit_sel];
		carry   = STATUS_IN[rrbo_pkg::CARRY_POS];
		rot_l   = {MEM_RDATA_IN[6:0], carry};
		rot_r   = {carry, MEM_RDATA_IN[7:1]};
	end

	logic fire;   // Fresh opcode executes this cycle
	assign fire = OP_VALID_IN && (state == rrbo_pkg::RRBO_EXEC) && !IRQ_ENTRY_IN;

	// Ready while decoding or discarding; stalls during return cycles
	assign OP_READY_OUT = (state != rrbo_pkg::RRBO_WAIT);
	assign MEM_ADDR_OUT = OPCODE_IN[8:0];

	// ==========================================================
	// Sequencer: multi-cycle returns and skip discard
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			state <= rrbo_pkg::RRBO_EXEC;
			cyc   <= 2'h0;
		end
		else
		begin
			case (state)
				rrbo_pkg::RRBO_EXEC:
				begin
					if (fire && (is_reti || is_retw))
					begin
						// Two more cycles after the decode cycle
						state <= rrbo_pkg::RRBO_WAIT;
						cyc   <= rrbo_pkg::RET_CYCLES - 2'h1;
					end
					else if (fire && is_skip && tested)
						state <= rrbo_pkg::RRBO_SKIP;
				end
				rrbo_pkg::RRBO_WAIT:
				begin
					if (cyc == 2'h1)
						state <= rrbo_pkg::RRBO_EXEC;
					cyc <= cyc - 2'h1;
				end
				rrbo_pkg::RRBO_SKIP:
				begin
					// Page-loads keep the discard going, one cycle each
					if (OP_VALID_IN && !is_page)
						state <= rrbo_pkg::RRBO_EXEC;
				end
				default:
					state <= rrbo_pkg::RRBO_EXEC;
			endcase
		end
	end

	// ==========================================================
	// Program counter
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
			pc <= rrbo_pkg::PC_RESET;
		else if (IRQ_ENTRY_IN)
			pc <= vec;
		else if (state == rrbo_pkg::RRBO_WAIT)
		begin
			if (cyc == 2'h1)
				pc <= ret_target;
		end
		else if (CALL_IN)
			pc <= CALL_TARGET_IN;
		else if (OP_VALID_IN && !(fire && (is_reti || is_retw)))
			pc <= pc + 16'h0001; // Skipped words advance the PC too
	end

	// Return target latched on decode
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
			ret_target <= rrbo_pkg::PC_RESET;
		else if (fire && is_reti)
			ret_target <= shadow_pc;
		else if (fire && is_retw)
			ret_target <= stack[sp - SPW'(1)];
	end

	// ==========================================================
	// Hardware call stack, private to call and return
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
			sp <= '0;
		else if (CALL_IN && fire == 1'b0)
			sp <= sp + SPW'(1);
		else if (fire && is_retw)
			sp <= sp - SPW'(1);
	end

	always_ff @(posedge SYS_CLK_IN)
	begin
		if (CALL_IN)
			stack[sp] <= pc + 16'h0001;
	end

	// ==========================================================
	// Shadow capture on interrupt entry
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			shadow_pc     <= rrbo_pkg::PC_RESET;
			shadow_status <= 8'h00;
			shadow_speed  <= 8'h00;
		end
		else if (IRQ_ENTRY_IN)
		begin
			shadow_pc     <= pc;
			shadow_status <= STATUS_IN;
			shadow_speed  <= SPEED_IN;
		end
	end

	// Vector pair, reloaded by an interrupt return option
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
			vec <= rrbo_pkg::VEC_RESET;
		else if (fire && is_reti && OPCODE_IN[rrbo_pkg::OPT_VEC])
			vec <= pc + 16'h0001;
	end

	// ==========================================================
	// Result registers; all option effects on the decode cycle
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			MEM_WR_OUT    <= '0;
			W_WE_OUT      <= 1'b0;
			W_OUT         <= 8'h00;
			STATUS_WE_OUT <= 1'b0;
			STATUS_OUT    <= 8'h00;
			SPEED_WE_OUT  <= 1'b0;
			SPEED_OUT     <= 8'h00;
			SIDE_OUT      <= '0;
		end
		else
		begin
			MEM_WR_OUT.we     <= 1'b0;
			MEM_WR_OUT.addr   <= OPCODE_IN[8:0];
			W_WE_OUT          <= 1'b0;
			STATUS_WE_OUT     <= 1'b0;
			SPEED_WE_OUT      <= 1'b0;
			SIDE_OUT.vec_we   <= 1'b0;
			SIDE_OUT.tmr_we   <= 1'b0;
			STATUS_OUT        <= STATUS_IN;
			if (fire)
			begin
				if (is_reti)
				begin
					// Each option acts on its own
					STATUS_WE_OUT <= 1'b1;
					STATUS_OUT    <= shadow_status;
					SPEED_WE_OUT  <= OPCODE_IN[rrbo_pkg::OPT_SPEED];
					SPEED_OUT     <= shadow_speed;
					SIDE_OUT.vec_we <= OPCODE_IN[rrbo_pkg::OPT_VEC];
					{SIDE_OUT.vec_hi, SIDE_OUT.vec_lo} <= pc + 16'h0001;
					SIDE_OUT.tmr_we <= OPCODE_IN[rrbo_pkg::OPT_TMR];
					SIDE_OUT.tmr    <= TMR_IN + W_IN;
				end
				else if (is_retw)
				begin
					// Status untouched, so page bits survive
					W_WE_OUT <= 1'b1;
					W_OUT    <= OPCODE_IN[7:0];
				end
				else if (is_rlm || is_rlw)
				begin
					STATUS_WE_OUT <= 1'b1;
					STATUS_OUT    <= {STATUS_IN[7:1], MEM_RDATA_IN[7]};
					MEM_WR_OUT.we   <= is_rlm;
					MEM_WR_OUT.data <= rot_l;
					W_WE_OUT      <= is_rlw;
					W_OUT         <= rot_l;
				end
				else if (is_rrm || is_rrw)
				begin
					STATUS_WE_OUT <= 1'b1;
					STATUS_OUT    <= {STATUS_IN[7:1], MEM_RDATA_IN[0]};
					MEM_WR_OUT.we   <= is_rrm;
					MEM_WR_OUT.data <= rot_r;
					W_WE_OUT      <= is_rrw;
					W_OUT         <= rot_r;
				end
				else if (is_setb)
				begin
					// No status write at all
					MEM_WR_OUT.we   <= 1'b1;
					MEM_WR_OUT.data <= MEM_RDATA_IN | (8'h01 << bit_sel);
				end
			end
		end
	end

	assign PC_OUT = pc;

endmodule

`default_nettype wire

/* File: rtl/rrbo_pkg.sv */
package rrbo_pkg;

	// ==========================================================
	// Opcode patterns
	localparam logic [15:0] RETI_MASK   = 16'hFFF8; // Fixed upper pattern of interrupt return
	localparam logic [15:0] RETI_CODE   = 16'h0008;
	localparam logic [15:0] RETW_MASK   = 16'hFF00; // Literal return
	localparam logic [15:0] RETW_CODE   = 16'h7800;
	localparam logic [15:0] ROT_MASK    = 16'hFE00; // Rotates share this mask
	localparam logic [15:0] RLM_CODE    = 16'h3600;
	localparam logic [15:0] RLW_CODE    = 16'h3400;
	localparam logic [15:0] RRM_CODE    = 16'h3200;
	localparam logic [15:0] RRW_CODE    = 16'h3000;
	localparam logic [15:0] BIT_MASK    = 16'hF000; // Bit-oriented group
	localparam logic [15:0] SKIP_CODE   = 16'h7000;
	localparam logic [15:0] SETB_CODE   = 16'h5000;
	localparam logic [15:0] PAGE_MASK   = 16'hFFF8; // Page-load instruction
	localparam logic [15:0] PAGE_CODE   = 16'h0010;

	// ==========================================================
	// Field positions
	localparam int OPT_SPEED = 2; // Reinstate speed option
	localparam int OPT_VEC   = 1; // Store PC+1 into vector
	localparam int OPT_TMR   = 0; // Add W to timer
	localparam int BITSEL_LO = 9; // Bit number field
	localparam int CARRY_POS = 0; // Carry within status

	// ==========================================================
	// Reset values and cycle counts
	localparam logic [15:0] VEC_RESET    = 16'h0000; // Vector after reset
	localparam logic [15:0] PC_RESET     = 16'h0000;
	localparam logic [1:0]  RET_CYCLES   = 2'h3;     // Returns take three cycles
	localparam logic [1:0]  SKIP_CYCLES  = 2'h2;     // Skip taken takes two

	// ==========================================================
	// Execution state
	typedef enum logic [2:0]
	{
		RRBO_EXEC = 3'b001, // Decode a fresh opcode
		RRBO_WAIT = 3'b010, // Extra cycles of a multi-cycle instruction
		RRBO_SKIP = 3'b100  // Discard skipped instructions
	} rrbo_state_t;

	// Carrier for the memory write-back
	typedef struct packed
	{
		logic       we;   // Write strobe
		logic [8:0] addr; // Byte address
		logic [7:0] data; // Byte written
	} rrbo_mem_wr_t;

	// Carrier for the vector / timer side effects
	typedef struct packed
	{
		logic       vec_we; // Load vector pair
		logic [7:0] vec_hi;
		logic [7:0] vec_lo;
		logic       tmr_we; // Load timer count
		logic [7:0] tmr;
	} rrbo_side_t;

endpackage
